// ===== hdl/mam_pkg.sv
// Overview of operation
// R01: program address is 24 bits, pc 23
// R02: user space capped at 0x7FFFFF, table escape
// R03: lower word even, upper word odd, 24-bit
// R04: pc stays even, steps by two
// R05: reset fetch at zero, start at two
// R06: vectors reserved below 0x000200
// R07: two vector tables, 0x000004 to 0x0000FF and 0x000100 to 0x0001FF
// R08: data addresses are 16-bit byte addresses
// R09: top bit clear memory, set visibility window
// R10: 30 kbytes implemented, others read zero
// R11: low byte even, high byte odd
// R12: post-modify adds one or two
// R13: byte read picks lane, low lane out
// R14: shared decode, separate byte write strobes
// R15: odd word access raises address error
// R16: misaligned read completes, write suppressed
// R17: byte load keeps register high byte
// R18: sign extend and zero extend operations
// R19: 0x0000 to 0x07FF holds special registers
// R20: unused special addresses read zero
// R21: word access with bit zero traps
package mam_pkg;
  localparam int PA_W = 24;
  localparam int PC_W = 23;
  localparam int DA_W = 16;
  localparam int DW = 16;
  localparam logic [23:0] PA_RESET = 24'h00_0000;
  localparam logic [23:0] PA_START_VEC = 24'h00_0002;
  localparam logic [23:0] PA_USER_MAX = 24'h7F_FFFF;
  localparam logic [23:0] PA_IVT1_LO = 24'h00_0004;
  localparam logic [23:0] PA_IVT1_HI = 24'h00_00FF;
  localparam logic [23:0] PA_IVT2_LO = 24'h00_0100;
  localparam logic [23:0] PA_IVT2_HI = 24'h00_01FF;
  localparam logic [23:0] PA_VEC_END = 24'h00_0200;
  localparam logic [23:0] PA_STEP = 24'h00_0002;
  localparam int TBLPG_CFG_BIT = 7;
  localparam logic [15:0] DA_SFR_HI = 16'h07FF;
  localparam logic [15:0] DA_RAM_END = 16'h7800;
  localparam int DA_TOP_BIT = 15;
  localparam int SFR_IMPL_WORDS = 16;
  localparam int RAM_WORDS = 15360;
  localparam int RAM_AW = 14;
  localparam logic [15:0] PTR_STEP_BYTE = 16'h0001;
  localparam logic [15:0] PTR_STEP_WORD = 16'h0002;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  typedef enum {PC_RESET, PC_RUN} mam_pc_e;
  typedef enum {DR_NONE, DR_SFR, DR_RAM, DR_PSV, DR_ZERO} mam_reg_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic byte_op;
    logic post_inc;
    logic [15:0] ea;
    logic [15:0] wdata;
    logic [3:0] wsel;
    logic ld_wreg;
    logic sign_ext;
    logic zero_ext;
  } mam_dreq_s;

  typedef struct packed {
    logic pc_adv;
    logic pc_back;
    logic pc_load;
    logic [22:0] pc_target;
    logic tbl_op;
    logic tbl_wr;
    logic [7:0] tbl_page;
    logic [15:0] tbl_off;
  } mam_preq_s;

  function automatic logic [15:0] mam_lane_pick(input logic [15:0] w,
                                                input logic a0);
    mam_lane_pick = a0 ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction
endpackage

// ===== hdl/mam_ram.sv
`timescale 1ns/1ns
module mam_ram
  import mam_pkg::*;
(
  input wire logic clk,
  input wire logic [RAM_AW-1:0] addr,
  input wire logic [1:0] be,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [7:0] lo_mem [RAM_WORDS];
  logic [7:0] hi_mem [RAM_WORDS];

  always_ff @(posedge clk) begin
    if (be[0]) begin
      lo_mem[addr] <= wdata[7:0];
    end
    if (be[1]) begin
      hi_mem[addr] <= wdata[15:8];
    end
    rdata <= {hi_mem[addr], lo_mem[addr]};
  end
endmodule

// ===== hdl/mam_top.sv
`timescale 1ns/1ns
module mam_top
  import mam_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire mam_preq_s PREQ,
  input wire mam_dreq_s DREQ,
  input wire logic [15:0] PSV_RDATA,
  output logic [23:0] PADDR,
  output logic PADDR_UPPER,
  output logic PADDR_CFG,
  output logic PADDR_VEC,
  output logic PADDR_IVT1,
  output logic PADDR_IVT2,
  output logic PADDR_DENY,
  output logic [15:0] RDATA,
  output logic RVALID,
  output logic [15:0] PTR_NEXT,
  output logic ADDR_ERR_TRAP,
  output logic [15:0] WREG_OUT,
  output logic [3:0] WREG_SEL
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // program address path
  // ---------------------------------------------------------------
  mam_pc_e pc_st_r, pc_st_nxt;
  logic [22:0] pc_r, pc_nxt;
  logic [23:0] paddr_r, paddr_nxt;
  logic upper_r, upper_nxt, cfg_r, cfg_nxt, vec_r, vec_nxt;
  logic ivt1_r, ivt1_nxt, ivt2_r, ivt2_nxt, deny_r, deny_nxt;
  logic [23:0] pa;

  always_comb begin
    pc_st_nxt = pc_st_r;
    pc_nxt = pc_r;
    case (pc_st_r)
      // R05: fetch at zero
      PC_RESET: begin
        pc_nxt = PA_RESET[22:0];
        pc_st_nxt = PC_RUN;
      end
      PC_RUN: begin
        // R04: even steps of two
        if (PREQ.pc_load) begin
          pc_nxt = {PREQ.pc_target[22:1], 1'b0};
        end else if (PREQ.pc_adv) begin
          pc_nxt = pc_r + PA_STEP[22:0];
        end else if (PREQ.pc_back) begin
          pc_nxt = pc_r - PA_STEP[22:0];
        end
      end
      default: pc_st_nxt = PC_RESET;
    endcase
    // R01: 24-bit program address
    if (PREQ.tbl_op) begin
      pa = {PREQ.tbl_page, PREQ.tbl_off};
    end else begin
      pa = {1'b0, pc_nxt};
    end
    paddr_nxt = pa;
    // R03: odd address selects upper word
    upper_nxt = PREQ.tbl_op & pa[0];
    // R02: config space only through table page bit
    cfg_nxt = PREQ.tbl_op & PREQ.tbl_page[TBLPG_CFG_BIT];
    deny_nxt = !PREQ.tbl_op & (pa > PA_USER_MAX);
    // R06: vector region
    vec_nxt = pa < PA_VEC_END;
    // R07: two vector tables
    ivt1_nxt = (pa >= PA_IVT1_LO) && (pa <= PA_IVT1_HI);
    ivt2_nxt = (pa >= PA_IVT2_LO) && (pa <= PA_IVT2_HI);
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pc_st_r <= PC_RESET;
      pc_r <= PA_RESET[22:0];
      paddr_r <= PA_RESET;
      upper_r <= 1'b0;
      cfg_r <= 1'b0;
      deny_r <= 1'b0;
      vec_r <= 1'b1;
      ivt1_r <= 1'b0;
      ivt2_r <= 1'b0;
    end else begin
      pc_st_r <= pc_st_nxt;
      pc_r <= pc_nxt;
      paddr_r <= paddr_nxt;
      upper_r <= upper_nxt;
      cfg_r <= cfg_nxt;
      deny_r <= deny_nxt;
      vec_r <= vec_nxt;
      ivt1_r <= ivt1_nxt;
      ivt2_r <= ivt2_nxt;
    end
  end

  assign PADDR = paddr_r;
  assign PADDR_UPPER = upper_r;
  assign PADDR_CFG = cfg_r;
  assign PADDR_DENY = deny_r;
  assign PADDR_VEC = vec_r;
  assign PADDR_IVT1 = ivt1_r;
  assign PADDR_IVT2 = ivt2_r;

  // ---------------------------------------------------------------
  // data space decode
  // ---------------------------------------------------------------
  logic [15:0] ea;
  logic word_op, mis, is_psv, is_sfr, is_ram, sfr_hit;
  logic [1:0] be;
  logic [15:0] ram_q;
  logic [15:0] sfr_q [SFR_IMPL_WORDS];
  logic [15:0] sfr_nxt [SFR_IMPL_WORDS];
  logic [RAM_AW-1:0] ram_a;

  // R08: 16-bit byte address
  assign ea = DREQ.ea;
  assign word_op = !DREQ.byte_op;
  // R15: odd word access is an error
  // R21: detect on bit zero
  assign mis = (DREQ.rd | DREQ.wr) & word_op & ea[0];
  // R09: top bit splits memory and window
  assign is_psv = ea[DA_TOP_BIT];
  // R19: special register region
  assign is_sfr = !is_psv && (ea <= DA_SFR_HI);
  assign sfr_hit = is_sfr && (ea[15:1] < 15'(SFR_IMPL_WORDS));
  // R10: implemented memory limit
  assign is_ram = !is_psv && !is_sfr && (ea < DA_RAM_END);
  assign ram_a = RAM_AW'((ea - (DA_SFR_HI + 16'h0001)) >> 1);

  // R14: byte strobes from address bit zero
  // R16: misaligned write suppressed
  always_comb begin
    be = 2'b00;
    if (DREQ.wr && !mis) begin
      if (word_op) begin
        be = 2'b11;
      end else begin
        be = ea[0] ? 2'b10 : 2'b01;
      end
    end
  end

  // R11: low byte even, high byte odd
  logic [15:0] wd_lane;
  assign wd_lane = DREQ.byte_op ? {DREQ.wdata[7:0], DREQ.wdata[7:0]}
                                : DREQ.wdata;

  mam_ram mam_ram_inst (
    .clk(CLK),
    .addr(ram_a),
    .be(is_ram ? be : 2'b00),
    .wdata(wd_lane),
    .rdata(ram_q)
  );

  // ---------------------------------------------------------------
  // special register file and working registers
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < SFR_IMPL_WORDS; i++) begin
      sfr_nxt[i] = sfr_q[i];
    end
    if (sfr_hit) begin
      if (be[0]) begin
        sfr_nxt[ea[4:1]][7:0] = wd_lane[7:0];
      end
      if (be[1]) begin
        sfr_nxt[ea[4:1]][15:8] = wd_lane[15:8];
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < SFR_IMPL_WORDS; i++) begin
        sfr_q[i] <= DATA_ZERO;
      end
    end else begin
      for (int i = 0; i < SFR_IMPL_WORDS; i++) begin
        sfr_q[i] <= sfr_nxt[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // read return, pointer update, trap
  // ---------------------------------------------------------------
  mam_reg_e src_r, src_nxt;
  logic a0_r, a0_nxt, byte_r, byte_nxt, mis_r;
  logic [15:0] sfr_rd_r, sfr_rd_nxt, rdata_r, rdata_nxt, psv_r;
  logic [15:0] ptr_r, ptr_nxt;
  logic trap_r, trap_nxt;
  logic ld_r, ld_nxt, sgnx_r, sgnx_nxt, zerx_r, zerx_nxt;
  logic [3:0] wsel_r, wsel_nxt;
  logic [15:0] wout_r, wout_nxt;
  logic [15:0] wbase_r, wbase_nxt;
  logic rv_r, rv_nxt;
  logic [15:0] word_sel;

  always_comb begin
    src_nxt = DR_NONE;
    if (DREQ.rd) begin
      if (is_psv) begin
        src_nxt = DR_PSV;
      end else if (sfr_hit) begin
        src_nxt = DR_SFR;
      end else if (is_ram) begin
        src_nxt = DR_RAM;
      end else begin
        // R20: unused special addresses read zero
        src_nxt = DR_ZERO;
      end
    end
    a0_nxt = ea[0];
    byte_nxt = DREQ.byte_op;
    sfr_rd_nxt = sfr_hit ? sfr_q[ea[4:1]] : DATA_ZERO;
    // R12: post-modify by operand size
    ptr_nxt = ea;
    if (DREQ.post_inc) begin
      ptr_nxt = ea + (DREQ.byte_op ? PTR_STEP_BYTE : PTR_STEP_WORD);
    end
    ld_nxt = DREQ.rd & DREQ.ld_wreg;
    sgnx_nxt = DREQ.sign_ext;
    zerx_nxt = DREQ.zero_ext;
    wsel_nxt = DREQ.wsel;
    wbase_nxt = sfr_q[DREQ.wsel];
  end

  always_comb begin
    case (src_r)
      DR_SFR: word_sel = sfr_rd_r;
      DR_RAM: word_sel = ram_q;
      DR_PSV: word_sel = psv_r;
      default: word_sel = DATA_ZERO;
    endcase
    // R13: byte onto low lane
    rdata_nxt = byte_r ? mam_lane_pick(word_sel, a0_r) : word_sel;
    rv_nxt = src_r != DR_NONE;
    // R16: read completes, trap in the same cycle as RVALID
    trap_nxt = mis_r;
    wout_nxt = wout_r;
    if (ld_r && rv_nxt) begin
      // R17: byte load keeps high byte
      wout_nxt = byte_r ? {wbase_r[15:8], rdata_nxt[7:0]} : rdata_nxt;
      // R18: sign and zero extension
      if (sgnx_r) begin
        wout_nxt = {{8{rdata_nxt[7]}}, rdata_nxt[7:0]};
      end else if (zerx_r) begin
        wout_nxt = {8'h00, rdata_nxt[7:0]};
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      src_r <= DR_NONE;
      a0_r <= 1'b0;
      byte_r <= 1'b0;
      mis_r <= 1'b0;
      sfr_rd_r <= DATA_ZERO;
      psv_r <= DATA_ZERO;
      ptr_r <= DATA_ZERO;
      ld_r <= 1'b0;
      sgnx_r <= 1'b0;
      zerx_r <= 1'b0;
      wsel_r <= 4'h0;
      wbase_r <= DATA_ZERO;
      rdata_r <= DATA_ZERO;
      rv_r <= 1'b0;
      trap_r <= 1'b0;
      wout_r <= DATA_ZERO;
    end else begin
      src_r <= src_nxt;
      a0_r <= a0_nxt;
      byte_r <= byte_nxt;
      mis_r <= mis;
      sfr_rd_r <= sfr_rd_nxt;
      psv_r <= PSV_RDATA;
      ptr_r <= ptr_nxt;
      ld_r <= ld_nxt;
      sgnx_r <= sgnx_nxt;
      zerx_r <= zerx_nxt;
      wsel_r <= wsel_nxt;
      wbase_r <= wbase_nxt;
      rdata_r <= rdata_nxt;
      rv_r <= rv_nxt;
      trap_r <= trap_nxt;
      wout_r <= wout_nxt;
    end
  end

  assign RDATA = rdata_r;
  assign RVALID = rv_r;
  assign PTR_NEXT = ptr_r;
  assign ADDR_ERR_TRAP = trap_r;
  assign WREG_OUT = wout_r;
  assign WREG_SEL = wsel_r;
endmodule

// ===== verification/mam_asserts.sv
`timescale 1ns/1ns
module mam_asserts
  import mam_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire mam_preq_s PREQ,
  input wire mam_dreq_s DREQ,
  input wire logic [23:0] PADDR,
  input wire logic PADDR_VEC,
  input wire logic PADDR_IVT1,
  input wire logic PADDR_IVT2,
  input wire logic PADDR_DENY,
  input wire logic RVALID,
  input wire logic [15:0] PTR_NEXT,
  input wire logic ADDR_ERR_TRAP
);
  // ---------------------------------------
  // checks at the ports
  // ---------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  wire mis = (DREQ.rd | DREQ.wr) & ~DREQ.byte_op & DREQ.ea[0];
  wire adv = PREQ.pc_adv & ~PREQ.pc_back & ~PREQ.pc_load & ~PREQ.tbl_op;
  sequence s_adv;
    adv;
  endsequence
  a_read_valid: assert property (
    RVALID == $past(DREQ.rd, 2)) else $error("read valid timing");
  a_trap_timing: assert property (
    ADDR_ERR_TRAP == $past(mis, 2)) else $error("trap timing");
  a_ptr_step: assert property (
    (DREQ.rd || DREQ.wr) |=> PTR_NEXT == ($past(DREQ.post_inc) ?
    $past(DREQ.ea) + ($past(DREQ.byte_op) ? PTR_STEP_BYTE :
    PTR_STEP_WORD) : $past(DREQ.ea))) else $error("pointer step");
  a_pc_step: assert property (
    s_adv ##1 s_adv |=> PADDR == $past(PADDR) + PA_STEP)
    else $error("pc step");
  a_pc_even: assert property (
    s_adv |=> !PADDR[0]) else $error("pc odd");
  a_tbl_addr: assert property (
    PREQ.tbl_op |=> PADDR == {$past(PREQ.tbl_page), $past(PREQ.tbl_off)})
    else $error("table address");
  a_vec_flag: assert property (
    PADDR_VEC == (PADDR < PA_VEC_END)) else $error("vector flag");
  a_ivt_one: assert property (
    PADDR_IVT1 == (PADDR >= PA_IVT1_LO && PADDR <= PA_IVT1_HI))
    else $error("first table flag");
  a_ivt_two: assert property (
    PADDR_IVT2 == (PADDR >= PA_IVT2_LO && PADDR <= PA_IVT2_HI))
    else $error("second table flag");
  a_user_ok: assert property (
    PADDR <= PA_USER_MAX |-> !PADDR_DENY) else $error("user denied");
  c_read: cover property (DREQ.rd);
  c_trap: cover property (mis);
  c_tbl: cover property (PREQ.tbl_op);
  c_run: cover property (s_adv ##1 s_adv);
endmodule

bind mam_top mam_asserts mam_asserts_inst (.CLK(CLK), .RST_N(RST_N),
  .PREQ(PREQ), .DREQ(DREQ), .PADDR(PADDR), .PADDR_VEC(PADDR_VEC),
  .PADDR_IVT1(PADDR_IVT1), .PADDR_IVT2(PADDR_IVT2),
  .PADDR_DENY(PADDR_DENY), .RVALID(RVALID), .PTR_NEXT(PTR_NEXT),
  .ADDR_ERR_TRAP(ADDR_ERR_TRAP));

// ===== verification/mam_psv_model.sv
`timescale 1ns/1ns
module mam_psv_model
  import mam_pkg::*;
(
  input wire logic clk,
  input wire mam_dreq_s dreq,
  output logic [15:0] psv_rdata
);
  logic [15:0] junk_r = 16'h3C3C;
  always_ff @(posedge clk) begin
    junk_r <= ~junk_r;
  end
  assign psv_rdata = (dreq.rd && dreq.ea[15]) ?
    {dreq.ea[7:0], ~dreq.ea[7:0]} : junk_r;
endmodule

// ===== verification/mam_top_tb.sv
`timescale 1ns/1ns
module mam_top_tb
  import mam_pkg::*;
;
  logic CLK = 0;
  logic RST_N = 0;
  mam_preq_s p = '0;
  mam_dreq_s d = '0;
  logic [15:0] psv, rdata, ptr;
  logic [23:0] paddr, prev;
  logic cfg, vec, iv1, iv2, deny, rvalid, trap;
  logic upper;
  logic [3:0] wsel_o;
  logic [15:0] wout;
  int fails = 0;
  int n_tests = 0;
  logic [15:0] ad [5] = '{16'h0004, 16'h0100, 16'h77FE, 16'h7800, 16'h0800};
  logic [15:0] ex [5] = '{16'hA5A5, 16'h0000, 16'hA5A5, 16'h0000, 16'hA5A5};
  always #4 CLK = ~CLK;
  mam_top mam_top_inst (.CLK(CLK), .RST_N(RST_N), .PREQ(p), .DREQ(d),
    .PSV_RDATA(psv), .PADDR(paddr), .PADDR_UPPER(upper), .PADDR_CFG(cfg),
    .PADDR_VEC(vec), .PADDR_IVT1(iv1), .PADDR_IVT2(iv2), .PADDR_DENY(deny),
    .RDATA(rdata), .RVALID(rvalid), .PTR_NEXT(ptr), .ADDR_ERR_TRAP(trap),
    .WREG_OUT(wout), .WREG_SEL(wsel_o));
  mam_psv_model mam_psv_model_inst (.clk(CLK), .dreq(d), .psv_rdata(psv));
  // ---------------------------------------
  // helpers
  // ---------------------------------------
  task chk(input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task chb(input logic s, input logic e);
    chk({23'h0, s}, {23'h0, e});
  endtask
  task acc(input logic r, w, b, i, input logic [15:0] a, wd, e,
           input logic t);
    @(posedge CLK);
    #1 d = '{rd:r, wr:w, byte_op:b, post_inc:i, ea:a, wdata:wd,
             default:'0};
    @(posedge CLK);
    #1 d = '0;
    chk(24'(ptr), 24'(i ? a + (b ? PTR_STEP_BYTE : PTR_STEP_WORD) : a));
    @(posedge CLK);
    #1 chb(rvalid, r);
    chb(trap, t);
    if (r && !t) chk(24'(rdata), 24'(e));
  endtask
  task give_verdict;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  task t_pc;
    @(posedge CLK);
    #1 p = '{pc_adv:1'b1, default:'0};
    @(posedge CLK);
    #1 prev = paddr;
    repeat (300) begin
      @(posedge CLK);
      #1 chk(paddr, prev + PA_STEP);
      chb(vec, paddr < PA_VEC_END);
      chb(iv1, paddr >= PA_IVT1_LO && paddr <= PA_IVT1_HI);
      chb(iv2, paddr >= PA_IVT2_LO && paddr <= PA_IVT2_HI);
      prev = paddr;
    end
    p = '{pc_back:1'b1, default:'0};
    repeat (4) begin
      @(posedge CLK);
      #1 chk(paddr, prev - PA_STEP);
      prev = paddr;
    end
    p = '{pc_load:1'b1, pc_target:23'h00_0101, default:'0};
    @(posedge CLK);
    #1 chk(paddr, 24'h00_0100);
    chb(iv2, 1'b1);
  endtask
  task t_tbl;
    @(posedge CLK);
    #1 p = '{tbl_op:1'b1, tbl_page:8'h80, tbl_off:16'h1234, default:'0};
    @(posedge CLK);
    #1 p = '0;
    chk(paddr, 24'h80_1234);
    chb(cfg, 1'b1);
    chb(deny, 1'b0);
    chb(upper, 1'b0);
    @(posedge CLK);
    #1 p = '{tbl_op:1'b1, tbl_page:8'h00, tbl_off:16'h0235, default:'0};
    @(posedge CLK);
    #1 p = '0;
    chk(paddr, 24'h00_0235);
    chb(upper, 1'b1);
    chb(cfg, 1'b0);
    chb(vec, 1'b0);
  endtask
  task t_data;
    foreach (ad[k]) begin
      acc(0, 1, 0, 0, ad[k], 16'hA5A5, 16'h0000, 0);
      acc(1, 0, 0, 1, ad[k], 16'h0000, ex[k], 0);
    end
    acc(0, 1, 1, 1, 16'h0801, 16'h1212, 16'h0000, 0);
    acc(1, 0, 0, 0, 16'h0800, 16'h0000, 16'h12A5, 0);
    acc(1, 0, 1, 1, 16'h0801, 16'h0000, 16'h0012, 0);
    acc(1, 0, 1, 0, 16'h0800, 16'h0000, 16'h00A5, 0);
    acc(0, 1, 0, 0, 16'h0802, 16'h5555, 16'h0000, 0);
    acc(0, 1, 0, 1, 16'h0803, 16'hDEAD, 16'h0000, 1);
    acc(1, 0, 0, 0, 16'h0802, 16'h0000, 16'h5555, 0);
    acc(1, 0, 0, 0, 16'h0801, 16'h0000, 16'h0000, 1);
    acc(1, 0, 0, 0, 16'h8004, 16'h0000, 16'h04FB, 0);
    acc(1, 0, 1, 0, 16'h8005, 16'h0000, 16'h0005, 0);
  endtask
  task wld(input logic b, sx, zx, input logic [15:0] a,
           input logic [3:0] ws, input logic [15:0] e);
    @(posedge CLK);
    #1 d = '{rd:1'b1, byte_op:b, ea:a, wsel:ws, ld_wreg:1'b1,
             sign_ext:sx, zero_ext:zx, default:'0};
    @(posedge CLK);
    #1 d = '0;
    chk(24'(wsel_o), 24'(ws));
    @(posedge CLK);
    #1 chk(24'(wout), 24'(e));
  endtask
  task t_wreg;
    wld(1, 0, 0, 16'h0801, 4'h2, 16'hA512);
    wld(0, 0, 0, 16'h0802, 4'h2, 16'h5555);
    wld(1, 1, 0, 16'h0800, 4'h2, 16'hFFA5);
    wld(1, 1, 0, 16'h0801, 4'h2, 16'h0012);
    wld(1, 0, 1, 16'h0800, 4'h2, 16'h00A5);
  endtask
  initial begin
    #20000;
    fails++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge CLK);
    #1 chk(paddr, PA_RESET);
    chb(vec, 1'b1);
    RST_N = 1;
    repeat (3) @(posedge CLK);
    #1 chk(paddr, PA_RESET);
    t_pc;
    t_tbl;
    t_data;
    t_wreg;
    give_verdict;
  end
endmodule
